// [core/usbdr_ctl.sv]
// Overview of operation
// - activity pending high while suspend unsafe, guarded
// - software sets guard before suspend or power-down
// - suspend gates link clock, transceiver low power
// - power bit enables whole controller, resets zero
// - clear power only after host/attach/dual-role off
// - status records last transfer endpoint number
// - direction bit: one transmit, zero receive
// - bank bit reports odd or even bank
// - live single-ended zero flag, both modes
// - halt bit stops processing, set by setup
// - host enable turns on both pull-downs
// - attach enable turns on D+ pull-up, device mode only
// - pointer clear returns all banks to even
// - resume driven while bit set, software times
// - live J-state flag in host mode, speed-dependent polarity
// - token busy high while token executes
// - bus reset driven while bit set, host
// - start-of-frame every millisecond while enabled
// - address low seven bits, speed top bit
// - token codes setup, in, out
// - software names an existing endpoint
// - software writes only defined token codes
// - dual-role off: pulls follow host/attach bits
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "usbdr_defines.svh"
module usbdr_ctl
    import usbdr_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `USBDR_MS_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    usbdr_link_if.ctl link
);
    usbdr_ctl_s r;
    usbdr_ctl_s next_r;
    logic ms_tick;
    logic sof_run;

    // frame timer stops in suspend or bus reset
    assign sof_run = r.pwr && !r.susp && r.host && r.en0 && !r.brst;

    usbdr_tick #(
        .CYCLES(MS_CYCLES)
    ) u_tick (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .run(sof_run),
        .tick(ms_tick)
    );

    always_comb begin
        logic acc;
        logic wr;
        logic [7:0] d;
        logic [7:0] a;
        logic live;
        logic rec;
        logic [3:0] rep;
        logic rtx;
        logic [4:0] idx;
        acc = 1'b0;
        wr = 1'b0;
        d = wb_dat_i[7:0];
        a = wb_adr_i[7:0];
        live = 1'b0;
        rec = 1'b0;
        rep = 4'h0;
        rtx = 1'b0;
        idx = 5'h0;
        next_r = r;

        acc = wb_cyc_i && wb_stb_i && !r.ack;
        wr = acc && wb_we_i && wb_sel_i[0];
        next_r.ack = acc;
        live = r.pwr && !r.susp;

        // line state sampling
        next_r.se0 = link.line_se0;
        next_r.jst = !link.line_se0 &&
            (r.ls ? !link.line_diff : link.line_diff);
        next_r.act = link.activity;

        // read data, captured with the ack
        next_r.rdata = 8'h00;
        if (acc) begin
            case (a)
                `USBDR_OFF_PWR: begin
                    next_r.rdata[`USBDR_PWR_ACT] = r.guard &&
                        (r.act || r.tok == USBDR_TOK_BUSY);
                    next_r.rdata[`USBDR_PWR_GUARD] = r.guard;
                    next_r.rdata[`USBDR_PWR_SUSP] = r.susp;
                    next_r.rdata[`USBDR_PWR_ON] = r.pwr;
                end
                `USBDR_OFF_STAT: begin
                    next_r.rdata = {r.last_ep, r.last_tx, r.last_odd,
                        2'b00};
                end
                `USBDR_OFF_CON: begin
                    next_r.rdata[`USBDR_CON_SE0] = r.se0;
                    next_r.rdata[`USBDR_CON_HOST] = r.host;
                    next_r.rdata[`USBDR_CON_RESUME] = r.resume;
                    next_r.rdata[`USBDR_CON_PPCLR] = r.ppclr;
                    next_r.rdata[`USBDR_CON_EN] = r.en0;
                    if (r.host) begin
                        next_r.rdata[`USBDR_CON_J] = r.jst;
                        next_r.rdata[`USBDR_CON_B5] =
                            (r.tok == USBDR_TOK_BUSY);
                        next_r.rdata[`USBDR_CON_BRST] = r.brst;
                    end else begin
                        next_r.rdata[`USBDR_CON_B5] = r.halt;
                    end
                end
                `USBDR_OFF_ADDR: begin
                    next_r.rdata = {r.host && r.ls, r.addr};
                end
                `USBDR_OFF_TOK: begin
                    next_r.rdata = {r.pid, r.tokep};
                end
                `USBDR_OFF_DRC: begin
                    next_r.rdata[`USBDR_DRC_DPUP] = r.drc_dpup;
                    next_r.rdata[`USBDR_DRC_DPDN] = r.drc_dpdn;
                    next_r.rdata[`USBDR_DRC_DMDN] = r.drc_dmdn;
                    next_r.rdata[`USBDR_DRC_ON] = r.drc_on;
                end
                default: begin
                    next_r.rdata = 8'h00;
                end
            endcase
        end

        // bus activity wakes the link; a same-cycle software write wins
        if (r.susp && r.act) begin
            next_r.susp = 1'b0;
        end

        // register writes
        next_r.tok_valid = 1'b0;
        if (wr) begin
            case (a)
                `USBDR_OFF_PWR: begin
                    next_r.guard = d[`USBDR_PWR_GUARD];
                    next_r.susp = d[`USBDR_PWR_SUSP];
                    next_r.pwr = d[`USBDR_PWR_ON];
                end
                `USBDR_OFF_CON: begin
                    next_r.host = d[`USBDR_CON_HOST];
                    next_r.resume = d[`USBDR_CON_RESUME];
                    next_r.ppclr = d[`USBDR_CON_PPCLR];
                    next_r.en0 = d[`USBDR_CON_EN];
                    if (r.host) begin
                        next_r.brst = d[`USBDR_CON_BRST];
                    end else begin
                        next_r.halt = d[`USBDR_CON_B5];
                    end
                end
                `USBDR_OFF_ADDR: begin
                    next_r.addr = d[6:0];
                    next_r.ls = d[`USBDR_ADDR_LS];
                end
                `USBDR_OFF_TOK: begin
                    if (r.tok == USBDR_TOK_IDLE) begin
                        next_r.pid = d[7:4];
                        next_r.tokep = d[3:0];
                        // reserved codes are kept, start nothing
                        if (r.host && live &&
                            (d[7:4] == `USBDR_PID_SETUP ||
                             d[7:4] == `USBDR_PID_IN ||
                             d[7:4] == `USBDR_PID_OUT)) begin
                            next_r.tok_valid = 1'b1;
                            next_r.tok = USBDR_TOK_BUSY;
                        end
                    end
                end
                `USBDR_OFF_DRC: begin
                    next_r.drc_dpup = d[`USBDR_DRC_DPUP];
                    next_r.drc_dpdn = d[`USBDR_DRC_DPDN];
                    next_r.drc_dmdn = d[`USBDR_DRC_DMDN];
                    next_r.drc_on = d[`USBDR_DRC_ON];
                end
                default: begin
                end
            endcase
        end

        // transfer completion, host and device mode
        if (r.tok == USBDR_TOK_BUSY && link.tok_done) begin
            next_r.tok = USBDR_TOK_IDLE;
            rec = 1'b1;
            rep = r.tokep;
            rtx = (r.pid != `USBDR_PID_IN);
        end else if (live && !r.host && r.en0 && !r.halt &&
                     link.xfer_done) begin
            rec = 1'b1;
            rep = link.xfer_ep;
            rtx = link.xfer_tx;
            if (link.xfer_setup) begin
                next_r.halt = 1'b1;
            end
        end
        if (rec) begin
            idx = {rep, rtx};
            next_r.last_ep = rep;
            next_r.last_tx = rtx;
            next_r.last_odd = r.pp[idx];
            next_r.pp[idx] = !r.pp[idx];
        end
        if (r.ppclr) begin
            next_r.pp = 32'h0;
        end
        if (!r.host) begin
            next_r.brst = 1'b0;
        end

        // link outputs
        next_r.link_on = live;
        next_r.low_power = r.susp;
        if (r.drc_on) begin
            next_r.dp_pullup = r.pwr && r.drc_dpup;
            next_r.dp_pulldown = r.pwr && r.drc_dpdn;
            next_r.dm_pulldown = r.pwr && r.drc_dmdn;
        end else begin
            next_r.dp_pullup = r.pwr && !r.host && r.en0;
            next_r.dp_pulldown = r.pwr && r.host;
            next_r.dm_pulldown = r.pwr && r.host;
        end
        next_r.drive_reset = live && r.host && r.brst;
        next_r.drive_resume = live && r.resume;
        next_r.sof = ms_tick && sof_run;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign wb_ack_o = r.ack;
    assign wb_dat_o = {24'h0, r.rdata};
    assign link.link_on = r.link_on;
    assign link.low_power = r.low_power;
    assign link.dp_pullup = r.dp_pullup;
    assign link.dp_pulldown = r.dp_pulldown;
    assign link.dm_pulldown = r.dm_pulldown;
    assign link.drive_reset = r.drive_reset;
    assign link.drive_resume = r.drive_resume;
    assign link.low_speed = r.ls;
    assign link.proc_halt = r.halt;
    assign link.sof_pulse = r.sof;
    assign link.tok_valid = r.tok_valid;
    assign link.tok_pid = r.pid;
    assign link.tok_ep = r.tokep;
    assign link.tok_addr = r.addr;
endmodule

// [core/usbdr_far.sv]
`timescale 1ns/1ps
`include "usbdr_defines.svh"
module usbdr_far
    import usbdr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    usbdr_link_if.far link,
    input wire logic user_se0,
    input wire logic user_diff,
    input wire logic user_activity,
    input wire logic xfer_req,
    input wire logic [3:0] xfer_ep,
    input wire logic xfer_tx,
    input wire logic xfer_setup,
    output logic xfer_ready,
    output logic tok_seen,
    output logic [3:0] tok_pid,
    output logic [3:0] tok_ep,
    output logic [6:0] tok_addr,
    output logic tok_low_speed,
    output logic sof_seen,
    output logic attached,
    output logic host_present,
    output logic reset_seen,
    output logic resume_seen
);
    usbdr_far_s r;
    usbdr_far_s next_r;

    always_comb begin
        next_r = r;
        next_r.tok_seen = 1'b0;
        next_r.tok_done = 1'b0;
        next_r.xfer_done = 1'b0;
        next_r.sof_seen = link.sof_pulse;
        next_r.attached = link.link_on & link.dp_pullup;
        next_r.host_present = link.dp_pulldown & link.dm_pulldown;
        next_r.reset_seen = link.drive_reset;
        next_r.resume_seen = link.drive_resume;
        // a driven bus reset shows as se0
        next_r.se0 = user_se0 | link.drive_reset;
        next_r.diff = user_diff;
        next_r.act = user_activity | link.drive_resume;
        case (r.st)
            USBDR_FAR_IDLE: begin
                if (link.tok_valid && link.link_on) begin
                    next_r.st = USBDR_FAR_TOKEN;
                    next_r.cnt = `USBDR_TOK_REPLY_CYCLES;
                    next_r.tok_seen = 1'b1;
                    next_r.pid = link.tok_pid;
                    next_r.ep = link.tok_ep;
                    next_r.addr = link.tok_addr;
                    next_r.low_speed = link.low_speed;
                end else if (xfer_req && r.xfer_ready) begin
                    next_r.st = USBDR_FAR_XFER;
                    next_r.xep = xfer_ep;
                    next_r.xtx = xfer_tx;
                    next_r.xsetup = xfer_setup;
                end
            end
            USBDR_FAR_TOKEN: begin
                next_r.cnt = r.cnt - 4'h1;
                if (r.cnt == 4'h1) begin
                    next_r.tok_done = 1'b1;
                    next_r.st = USBDR_FAR_IDLE;
                end
            end
            USBDR_FAR_XFER: begin
                next_r.xfer_done = 1'b1;
                next_r.st = USBDR_FAR_IDLE;
            end
            default: begin
                next_r.st = USBDR_FAR_IDLE;
            end
        endcase
        // none to a detached, halted or asleep end
        next_r.xfer_ready = (next_r.st == USBDR_FAR_IDLE) &&
            link.link_on && link.dp_pullup && !link.proc_halt &&
            !link.tok_valid;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign link.line_se0 = r.se0;
    assign link.line_diff = r.diff;
    assign link.activity = r.act;
    assign link.tok_done = r.tok_done;
    assign link.xfer_done = r.xfer_done;
    assign link.xfer_ep = r.xep;
    assign link.xfer_tx = r.xtx;
    assign link.xfer_setup = r.xsetup;
    assign xfer_ready = r.xfer_ready;
    assign tok_seen = r.tok_seen;
    assign tok_pid = r.pid;
    assign tok_ep = r.ep;
    assign tok_addr = r.addr;
    assign tok_low_speed = r.low_speed;
    assign sof_seen = r.sof_seen;
    assign attached = r.attached;
    assign host_present = r.host_present;
    assign reset_seen = r.reset_seen;
    assign resume_seen = r.resume_seen;
endmodule

// [core/usbdr_tick.sv]
`timescale 1ns/1ps
`include "usbdr_defines.svh"
module usbdr_tick
    import usbdr_pkg::*;
#(
    parameter int unsigned CYCLES = `USBDR_MS_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic run,
    output logic tick
);
    usbdr_tick_s r;
    usbdr_tick_s next_r;

    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        // a stop restarts the count: full first period
        if (!run) begin
            next_r.cnt = 32'h0;
        end else if (r.cnt == 32'(CYCLES - 1)) begin
            next_r.cnt = 32'h0;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 32'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign tick = r.tick;
endmodule

// [shared/usbdr_defines.svh]
`ifndef USBDR_DEFINES_SVH
`define USBDR_DEFINES_SVH

// register byte offsets on the bus, one 32-bit word each
`define USBDR_OFF_PWR 8'h00
`define USBDR_OFF_STAT 8'h04
`define USBDR_OFF_CON 8'h08
`define USBDR_OFF_ADDR 8'h0c
`define USBDR_OFF_TOK 8'h10
`define USBDR_OFF_DRC 8'h14

// power control fields
`define USBDR_PWR_ACT 7
`define USBDR_PWR_GUARD 4
`define USBDR_PWR_SUSP 1
`define USBDR_PWR_ON 0

// transfer status fields
`define USBDR_STAT_EP_LSB 4
`define USBDR_STAT_DIR 3
`define USBDR_STAT_PINGPONG_BANK_INDICATOR 2

// control fields (bit 5 is halt in device mode, busy in host mode)
`define USBDR_CON_J 7
`define USBDR_CON_SE0 6
`define USBDR_CON_B5 5
`define USBDR_CON_BRST 4
`define USBDR_CON_HOST 3
`define USBDR_CON_RESUME 2
`define USBDR_CON_PPCLR 1
`define USBDR_CON_EN 0

// address and token fields
`define USBDR_ADDR_LS 7
`define USBDR_TOK_PID_LSB 4

// dual-role register fields
`define USBDR_DRC_DPUP 7
`define USBDR_DRC_DPDN 5
`define USBDR_DRC_DMDN 4
`define USBDR_DRC_ON 2

// token type codes
`define USBDR_PID_SETUP 4'hd
`define USBDR_PID_IN 4'h9
`define USBDR_PID_OUT 4'h1

// timing
`define USBDR_CLK_NS 10
`define USBDR_MS_NS 1000000
`define USBDR_MS_CYCLES (`USBDR_MS_NS / `USBDR_CLK_NS)
`define USBDR_TOK_REPLY_CYCLES 4'h8

`endif

// [shared/usbdr_link_if.sv]
`timescale 1ns/1ps
interface usbdr_link_if;
    logic link_on;
    logic low_power;
    logic dp_pullup;
    logic dp_pulldown;
    logic dm_pulldown;
    logic drive_reset;
    logic drive_resume;
    logic low_speed;
    logic proc_halt;
    logic sof_pulse;
    logic tok_valid;
    logic [3:0] tok_pid;
    logic [3:0] tok_ep;
    logic [6:0] tok_addr;
    logic line_se0;
    logic line_diff;
    logic activity;
    logic tok_done;
    logic xfer_done;
    logic [3:0] xfer_ep;
    logic xfer_tx;
    logic xfer_setup;

    modport ctl (
        output link_on, low_power, dp_pullup, dp_pulldown, dm_pulldown,
        output drive_reset, drive_resume, low_speed, proc_halt,
        output sof_pulse, tok_valid, tok_pid, tok_ep, tok_addr,
        input line_se0, line_diff, activity, tok_done,
        input xfer_done, xfer_ep, xfer_tx, xfer_setup
    );

    modport far (
        input link_on, low_power, dp_pullup, dp_pulldown, dm_pulldown,
        input drive_reset, drive_resume, low_speed, proc_halt,
        input sof_pulse, tok_valid, tok_pid, tok_ep, tok_addr,
        output line_se0, line_diff, activity, tok_done,
        output xfer_done, xfer_ep, xfer_tx, xfer_setup
    );
endinterface

// [shared/usbdr_pkg.sv]
package usbdr_pkg;

    typedef enum logic [0:0] {
        USBDR_TOK_IDLE,
        USBDR_TOK_BUSY
    } usbdr_tok_e;

    typedef enum logic [1:0] {
        USBDR_FAR_IDLE,
        USBDR_FAR_TOKEN,
        USBDR_FAR_XFER
    } usbdr_far_e;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic guard;
        logic susp;
        logic pwr;
        logic [3:0] last_ep;
        logic last_tx;
        logic last_odd;
        logic halt;
        logic host;
        logic resume;
        logic ppclr;
        logic en0;
        logic brst;
        logic [6:0] addr;
        logic ls;
        logic [3:0] pid;
        logic [3:0] tokep;
        logic drc_on;
        logic drc_dpup;
        logic drc_dpdn;
        logic drc_dmdn;
        usbdr_tok_e tok;
        logic [31:0] pp;
        logic se0;
        logic jst;
        logic act;
        logic link_on;
        logic low_power;
        logic dp_pullup;
        logic dp_pulldown;
        logic dm_pulldown;
        logic drive_reset;
        logic drive_resume;
        logic sof;
        logic tok_valid;
    } usbdr_ctl_s;

    typedef struct packed {
        usbdr_far_e st;
        logic [3:0] cnt;
        logic tok_seen;
        logic [3:0] pid;
        logic [3:0] ep;
        logic [6:0] addr;
        logic low_speed;
        logic tok_done;
        logic xfer_done;
        logic [3:0] xep;
        logic xtx;
        logic xsetup;
        logic sof_seen;
        logic attached;
        logic host_present;
        logic reset_seen;
        logic resume_seen;
        logic se0;
        logic diff;
        logic act;
        logic xfer_ready;
    } usbdr_far_s;

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } usbdr_tick_s;

endpackage

// [verif/test_usb_dual_role_core_control.sv]
`timescale 1ns/1ps
module test_usb_dual_role_core_control;
    import usbdr_pkg::*;
    typedef struct packed {
        logic we;
        logic [7:0] adr;
        logic [7:0] val;
    } usbdr_row_s;
    localparam int MS = 20;
    int n_mismatch = 0;
    int check_count = 0;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic se0 = 1'b0;
    logic diff = 1'b0;
    logic act = 1'b0;
    logic req = 1'b0;
    logic xtx = 1'b0;
    logic xset = 1'b0;
    logic [3:0] xep = 4'h0;
    logic rdy, f_seen, f_ls, f_sof, f_att, f_host, f_rst, f_res;
    logic [3:0] f_pid, f_ep;
    logic [6:0] f_addr;
    logic [3:0] pids [3] = '{4'hd, 4'h9, 4'h1};
    usbdr_row_s rows [21] = '{
        '{1'b0, 8'h00, 8'h00}, '{1'b0, 8'h04, 8'h00},
        '{1'b0, 8'h08, 8'h00}, '{1'b0, 8'h0c, 8'h00},
        '{1'b0, 8'h10, 8'h00}, '{1'b1, 8'h00, 8'h01},
        '{1'b0, 8'h00, 8'h01}, '{1'b1, 8'h0c, 8'hff},
        '{1'b0, 8'h0c, 8'h7f}, '{1'b1, 8'h10, 8'h23},
        '{1'b0, 8'h10, 8'h23}, '{1'b1, 8'h04, 8'hff},
        '{1'b0, 8'h04, 8'h00}, '{1'b1, 8'h18, 8'haa},
        '{1'b0, 8'h18, 8'h00}, '{1'b1, 8'h14, 8'h04},
        '{1'b0, 8'h14, 8'h04}, '{1'b1, 8'h14, 8'h00},
        '{1'b1, 8'h00, 8'h11}, '{1'b0, 8'h00, 8'h11},
        '{1'b1, 8'h00, 8'h01}};

    always #5 mclk = ~mclk;

    usbdr_link_if link ();
    usbdr_ctl #(.MS_CYCLES(MS)) u_usbdr_ctl (
        .mclk(mclk), .rst(rst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
    usbdr_far u_usbdr_far (
        .mclk(mclk), .rst(rst), .ce(1'b1), .link(link), .user_se0(se0),
        .user_diff(diff), .user_activity(act), .xfer_req(req),
        .xfer_ep(xep), .xfer_tx(xtx), .xfer_setup(xset), .xfer_ready(rdy),
        .tok_seen(f_seen), .tok_pid(f_pid), .tok_ep(f_ep),
        .tok_addr(f_addr), .tok_low_speed(f_ls), .sof_seen(f_sof),
        .attached(f_att), .host_present(f_host), .reset_seen(f_rst),
        .resume_seen(f_res));
    usbdr_assertions u_usbdr_assertions (
        .mclk(mclk), .rst(rst), .link_on(link.link_on),
        .low_power(link.low_power), .dp_pullup(link.dp_pullup),
        .drive_reset(link.drive_reset), .drive_resume(link.drive_resume),
        .proc_halt(link.proc_halt), .sof_pulse(link.sof_pulse),
        .tok_valid(link.tok_valid), .tok_pid(link.tok_pid),
        .line_se0(link.line_se0), .tok_done(link.tok_done),
        .xfer_done(link.xfer_done), .xfer_setup(link.xfer_setup));

    task automatic chk_reg(input string nm, input logic [7:0] e,
            input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_reg(nm, {7'h0, e}, {7'h0, g});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // no assumed latency; ack or the 50-cycle bound ends a wait
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [7:0] d, input logic [3:0] s, output logic [7:0] q);
        int n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {24'h0, a};
        sel <= s;
        wdat <= {24'h0, d};
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        chk_bit("ack", 1'b1, ack);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, 4'hf, q);
        chk_reg($sformatf("reg %h", a), e, q);
    endtask

    task automatic xfer(input logic [3:0] e, input logic t, input logic s);
        int n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        req <= 1'b1;
        xep <= e;
        xtx <= t;
        xset <= s;
        @(posedge mclk);
        req <= 1'b0;
        tick(4);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        end_sim;
    end

    initial begin
        logic [7:0] q;
        int n;
        logic [3:0] e;
        tick(16);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].we) wr(rows[i].adr, rows[i].val);
            else rd(rows[i].adr, rows[i].val);
        end
        chk_bit("link_on", 1'b1, link.link_on);
        wb(1'b1, 8'h0c, 8'h11, 4'h0, q);
        rd(8'h0c, 8'h7f);
        wr(8'h08, 8'h01);
        tick(2);
        chk_bit("attached", 1'b1, f_att);
        xfer(4'h5, 1'b1, 1'b0);
        rd(8'h04, 8'h58);
        xfer(4'h5, 1'b1, 1'b0);
        rd(8'h04, 8'h5c);
        wr(8'h08, 8'h03);
        wr(8'h08, 8'h01);
        xfer(4'h5, 1'b1, 1'b0);
        rd(8'h04, 8'h58);
        xfer(4'hf, 1'b1, 1'b0);
        rd(8'h04, 8'hf8);
        xfer(4'h9, 1'b0, 1'b1);
        rd(8'h04, 8'h90);
        rd(8'h08, 8'h21);
        chk_bit("ready", 1'b0, rdy);
        wr(8'h08, 8'h01);
        act <= 1'b1;
        wr(8'h00, 8'h11);
        rd(8'h00, 8'h91);
        wr(8'h00, 8'h01);
        rd(8'h00, 8'h01);
        act <= 1'b0;
        wr(8'h00, 8'h03);
        tick(2);
        chk_bit("link_on", 1'b0, link.link_on);
        chk_bit("low_power", 1'b1, link.low_power);
        act <= 1'b1;
        tick(4);
        rd(8'h00, 8'h01);
        act <= 1'b0;
        se0 <= 1'b1;
        tick(3);
        rd(8'h08, 8'h41);
        se0 <= 1'b0;
        wr(8'h08, 8'h08);
        tick(2);
        chk_bit("host", 1'b1, f_host);
        chk_bit("pullup", 1'b0, link.dp_pullup);
        rd(8'h0c, 8'hff);
        rd(8'h08, 8'h88);
        diff <= 1'b1;
        tick(3);
        rd(8'h08, 8'h08);
        wr(8'h0c, 8'h05);
        rd(8'h08, 8'h88);
        diff <= 1'b0;
        foreach (pids[i]) begin
            e = 4'(i + 2);
            wr(8'h10, {pids[i], e});
            wr(8'h10, {pids[i], 4'hf});
            rd(8'h08, 8'h28);
            q = 8'h20;
            for (int k = 0; k < 20 && q[5] !== 1'b0; k++)
                wb(1'b0, 8'h08, 8'h00, 4'hf, q);
            chk_reg("busy", 8'h08, q);
            chk_reg("pid", {4'h0, pids[i]}, {4'h0, f_pid});
            chk_reg("ep", {4'h0, e}, {4'h0, f_ep});
            chk_reg("addr", 8'h05, {f_ls, f_addr});
            rd(8'h04, {e, pids[i] != 4'h9, 3'h0});
        end
        wr(8'h10, 8'h52);
        rd(8'h08, 8'h08);
        wr(8'h08, 8'h09);
        n = 0;
        while (f_sof !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (f_sof !== 1'b1 && n < 100);
        chk_reg("sof gap", 8'(MS), 8'(n));
        wr(8'h08, 8'h08);
        tick(3);
        n = 0;
        repeat (60) begin
            @(posedge mclk);
            if (f_sof === 1'b1) n++;
        end
        chk_reg("sof off", 8'h00, 8'(n));
        wr(8'h08, 8'h18);
        tick(3);
        chk_bit("bus reset", 1'b1, f_rst);
        rd(8'h08, 8'h58);
        wr(8'h08, 8'h0c);
        tick(3);
        chk_bit("resume", 1'b1, f_res);
        wr(8'h08, 8'h08);
        tick(3);
        chk_bit("resume", 1'b0, f_res);
        wr(8'h08, 8'h00);
        wr(8'h00, 8'h00);
        tick(2);
        chk_bit("link_on", 1'b0, link.link_on);
        wr(8'h0c, 8'h33);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        rd(8'h0c, 8'h00);
        end_sim;
    end
endmodule

// [verif/usbdr_assertions.sv]
`timescale 1ns/1ps
module usbdr_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic link_on,
    input wire logic low_power,
    input wire logic dp_pullup,
    input wire logic drive_reset,
    input wire logic drive_resume,
    input wire logic proc_halt,
    input wire logic sof_pulse,
    input wire logic tok_valid,
    input wire logic [3:0] tok_pid,
    input wire logic line_se0,
    input wire logic tok_done,
    input wire logic xfer_done,
    input wire logic xfer_setup
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_suspend_gates: assert property (low_power |-> !link_on)
        else $error("link on while suspended");
    a_reset_live: assert property (drive_reset |-> link_on)
        else $error("bus reset driven while off");
    a_resume_live: assert property (drive_resume |-> link_on)
        else $error("resume driven while off");
    a_se0_follows: assert property ($past(drive_reset) |-> line_se0)
        else $error("line se0 missing during reset");
    a_sof_pulse: assert property (sof_pulse |=> !sof_pulse)
        else $error("frame marker longer than one cycle");
    a_tok_code: assert property (
        tok_valid |-> tok_pid inside {4'hd, 4'h9, 4'h1})
        else $error("reserved token code started");
    a_tok_single: assert property (tok_valid |=> !tok_valid [*8])
        else $error("token started while busy");
    a_tok_reply: assert property (tok_valid |-> ##9 tok_done)
        else $error("token reply late");
    a_done_cause: assert property (tok_done |-> $past(tok_valid, 9))
        else $error("token done without token");
    // setup beats a same-cycle software clear
    a_halt_setup: assert property (
        xfer_done && xfer_setup && link_on && dp_pullup |=> proc_halt)
        else $error("halt not set by setup");

    c_token: cover property (tok_done);
    c_setup: cover property (xfer_done && xfer_setup);
    c_frame: cover property (sof_pulse);
endmodule
